// *** inc/sfr_pkg.sv ***
// Constants, reset tables and address decoding of the register map
// Functional notes
// - Unimplemented addresses and bit positions read back as zero.
// - Mirrored core registers decode the same in either data bank.
// - The upper program counter bits have no direct read or write path.
// - The five-bit high buffer holds its value until it is copied later.
// - Non-power-up reset values apply on external pin or watchdog reset.
// - Unknown bits start anyhow, unchanged bits keep, conditional follow cause.
package sfr_pkg;

  // ****************************************************************
  // Register indices
  // ****************************************************************
  localparam logic [7:0] IDX_INDIRECT_ACCESS_PORT    = 8'h00;
  localparam logic [7:0] IDX_TIMER_ZERO_COUNT        = 8'h01;
  localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW     = 8'h02;
  localparam logic [7:0] IDX_CPU_STATUS_WORD         = 8'h03;
  localparam logic [7:0] IDX_INDIRECT_POINTER        = 8'h04;
  localparam logic [7:0] IDX_PORT_A_LATCH            = 8'h05;
  localparam logic [7:0] IDX_PORT_B_LATCH            = 8'h06;
  localparam logic [7:0] IDX_PORT_C_LATCH            = 8'h07;
  localparam logic [7:0] IDX_PC_HIGH_BUFFER          = 8'h0A;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL       = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS    = 8'h0C;
  localparam logic [7:0] IDX_TIMER_ONE_LOW           = 8'h0E;
  localparam logic [7:0] IDX_TIMER_ONE_HIGH          = 8'h0F;
  localparam logic [7:0] IDX_TIMER_ONE_CONTROL       = 8'h10;
  localparam logic [7:0] IDX_TIMER_TWO_COUNT         = 8'h11;
  localparam logic [7:0] IDX_TIMER_TWO_CONTROL       = 8'h12;
  localparam logic [7:0] IDX_SERIAL_PORT_BUFFER      = 8'h13;
  localparam logic [7:0] IDX_SERIAL_PORT_CONTROL     = 8'h14;
  localparam logic [7:0] IDX_CAPTURE_COMPARE_LOW     = 8'h15;
  localparam logic [7:0] IDX_CAPTURE_COMPARE_HIGH    = 8'h16;
  localparam logic [7:0] IDX_CAPTURE_COMPARE_CONTROL = 8'h17;
  localparam logic [7:0] IDX_LAST_SFR                = 8'h17;
  localparam logic [7:0] BANK_OFFSET_MASK            = 8'h7F;
  localparam logic [7:0] GPR_BASE                    = 8'h20;
  localparam logic [7:0] GPR_LIMIT                   = 8'h80;
  localparam int         GPR_WORDS = int'(GPR_LIMIT) - int'(GPR_BASE);
  localparam int         GPR_AW                      = 7;
  localparam logic [9:0] IDX_IRQ_STATUS              = 10'h100;
  localparam logic [9:0] IDX_IRQ_MASK                = 10'h101;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int         PC_HIGH_W         = 5;
  localparam int         STATUS_TO_BIT     = 4;
  localparam int         STATUS_PD_BIT     = 3;
  localparam logic [7:0] STATUS_READ_ONLY  = 8'h18;
  localparam logic [7:0] STATUS_POR_VALUE  = 8'h18;
  localparam int         EVT_W             = 7;
  localparam int         EVT_PIR_W         = 4;
  localparam int         EVT_INTERRUPT_CONTROL_W      = 3;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  // Core registers reached from both banks
  function automatic logic [7:0] sfr_fold(input logic [7:0] idx);
    logic [7:0] low;
    low = idx & BANK_OFFSET_MASK;
    if (low inside {IDX_INDIRECT_ACCESS_PORT, IDX_PROGRAM_COUNTER_LOW,
                    IDX_CPU_STATUS_WORD, IDX_INDIRECT_POINTER,
                    IDX_PC_HIGH_BUFFER, IDX_INTERRUPT_CONTROL})
      return low;
    return idx;
  endfunction : sfr_fold

  // Location reached by an access, following the indirect pointer
  function automatic logic [7:0] sfr_resolve(input logic [7:0] idx,
                                             input logic [7:0] ptr);
    logic [7:0] loc;
    loc = sfr_fold(idx);
    if (loc == IDX_INDIRECT_ACCESS_PORT)
      loc = sfr_fold(ptr);
    return loc;
  endfunction : sfr_resolve

  // Bits that hold storage
  function automatic logic [7:0] sfr_impl_mask(input logic [7:0] loc);
    case (loc)
      IDX_TIMER_ZERO_COUNT, IDX_PROGRAM_COUNTER_LOW, IDX_CPU_STATUS_WORD,
      IDX_INDIRECT_POINTER, IDX_PORT_B_LATCH, IDX_PORT_C_LATCH,
      IDX_INTERRUPT_CONTROL, IDX_TIMER_ONE_LOW, IDX_TIMER_ONE_HIGH,
      IDX_TIMER_TWO_COUNT, IDX_SERIAL_PORT_BUFFER, IDX_SERIAL_PORT_CONTROL,
      IDX_CAPTURE_COMPARE_LOW, IDX_CAPTURE_COMPARE_HIGH: return 8'hFF;
      IDX_PORT_A_LATCH, IDX_TIMER_ONE_CONTROL,
      IDX_CAPTURE_COMPARE_CONTROL:                       return 8'h3F;
      IDX_PC_HIGH_BUFFER:                                return 8'h1F;
      IDX_PERIPHERAL_IRQ_FLAGS:                          return 8'hCF;
      IDX_TIMER_TWO_CONTROL:                             return 8'h7F;
      default:                                           return 8'h00;
    endcase
  endfunction : sfr_impl_mask

  // Bits forced by a reset; all other bits keep their value
  function automatic logic [7:0] sfr_rst_mask(input logic [7:0] loc,
                                              input logic       por);
    case (loc)
      IDX_PROGRAM_COUNTER_LOW, IDX_TIMER_TWO_COUNT,
      IDX_SERIAL_PORT_CONTROL:     return 8'hFF;
      IDX_CPU_STATUS_WORD:         return por ? 8'hF8 : 8'hF8;
      IDX_PC_HIGH_BUFFER:          return 8'h1F;
      IDX_INTERRUPT_CONTROL:       return 8'hFE;
      IDX_PERIPHERAL_IRQ_FLAGS:    return 8'hCF;
      IDX_TIMER_ONE_CONTROL:       return por ? 8'h3F : 8'h00;
      IDX_TIMER_TWO_CONTROL:       return 8'h7F;
      IDX_CAPTURE_COMPARE_CONTROL: return 8'h3F;
      default:                     return 8'h00;
    endcase
  endfunction : sfr_rst_mask

endpackage : sfr_pkg

// *** inc/sfr_ram_if.sv ***
// Port between the register map and its general-purpose data memory
`timescale 1ns/10ps
interface sfr_ram_if;
  logic                    we;
  logic [sfr_pkg::GPR_AW-1:0] waddr;
  logic [7:0]              wdata;
  logic [sfr_pkg::GPR_AW-1:0] raddr;
  logic [7:0]              rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface : sfr_ram_if

// *** verilog/sfr_gpr_ram.sv ***
// General-purpose data memory behind the indirect and direct accesses
`timescale 1ns/10ps
module sfr_gpr_ram
  import sfr_pkg::*;
#(
  parameter int WORDS = GPR_WORDS
) (
  input  wire logic clock,  // Core clock
  sfr_ram_if.mem    bus     // Memory port
);

  logic [7:0] mem_q [0:WORDS-1];

  always_ff @(posedge clock) begin
    if (bus.we)
      mem_q[bus.waddr] <= bus.wdata;
  end

  assign bus.rdata = mem_q[bus.raddr];

endmodule : sfr_gpr_ram

// *** verilog/sfr_top.sv ***
// Bank 0 special-function register map with AXI4-Lite access
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module sfr_top
  import sfr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clock,           // Core clock
  input  wire logic              nrst,            // Sync reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // Write address
  input  wire logic [2:0]        s_axi_awprot,    // Unused
  input  wire logic              s_axi_awvalid,   // Write addr valid
  output logic                   s_axi_awready,   // Write addr ready
  input  wire logic [31:0]       s_axi_wdata,     // Write data
  input  wire logic [3:0]        s_axi_wstrb,     // Byte enables
  input  wire logic              s_axi_wvalid,    // Write data valid
  output logic                   s_axi_wready,    // Write data ready
  output logic [1:0]             s_axi_bresp,     // Write response
  output logic                   s_axi_bvalid,    // Write resp valid
  input  wire logic              s_axi_bready,    // Write resp ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,    // Read address
  input  wire logic [2:0]        s_axi_arprot,    // Unused
  input  wire logic              s_axi_arvalid,   // Read addr valid
  output logic                   s_axi_arready,   // Read addr ready
  output logic [31:0]            s_axi_rdata,     // Read data
  output logic [1:0]             s_axi_rresp,     // Read response
  output logic                   s_axi_rvalid,    // Read data valid
  input  wire logic              s_axi_rready,    // Read data ready
  input  wire logic              rst_power_cause, // Reset is POR/BOR
  input  wire logic              rst_timeout_bit, // TO after non-POR reset
  input  wire logic              rst_powerdown_bit, // PD after non-POR reset
  input  wire logic [EVT_W-1:0]  event_in,        // Flag set pulses
  input  wire logic [5:0]        port_a_pins,     // Port A pin levels
  input  wire logic [7:0]        port_b_pins,     // Port B pin levels
  input  wire logic [7:0]        port_c_pins,     // Port C pin levels
  output logic [5:0]             port_a_out,      // Port A latch
  output logic [7:0]             port_b_out,      // Port B latch
  output logic [7:0]             port_c_out,      // Port C latch
  output logic [12:0]            pc_out,          // Program counter
  output logic                   irq              // Interrupt level
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]           reg_q [1:IDX_LAST_SFR];
  logic [7:0]           reg_d [1:IDX_LAST_SFR];
  logic [PC_HIGH_W-1:0] pch_q, pch_d;
  logic [EVT_W-1:0]     ist_q, ist_d;
  logic [EVT_W-1:0]     imask_q, imask_d;
  logic                 aw_hold_q, aw_hold_d;
  logic [9:0]           aw_idx_q, aw_idx_d;
  logic                 w_hold_q, w_hold_d;
  logic [7:0]           wd_q, wd_d;
  logic                 wstb_q, wstb_d;
  logic                 bvalid_q, bvalid_d;
  logic [1:0]           bresp_q, bresp_d;
  logic                 rvalid_q, rvalid_d;
  logic [7:0]           rd_q, rd_d;
  logic [1:0]           rresp_q, rresp_d;
  logic                 wr_fire;
  logic                 wr_sfr;
  logic [7:0]           wr_loc;
  logic [7:0]           rd_loc;
  logic [9:0]           ar_idx;
  logic [7:0]           rd_val;
  logic [1:0]           rd_resp;
  logic [7:0]           indirect_pointer;

  sfr_ram_if ram_bus ();

  sfr_gpr_ram #(
    .WORDS (GPR_WORDS)
  ) u_ram (
    .clock (clock),
    .bus   (ram_bus)
  );

  assign indirect_pointer = reg_q[IDX_INDIRECT_POINTER];

  // ****************************************************************
  // AXI4-Lite handshakes
  // ****************************************************************
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h000000, rd_q};
  assign wr_fire       = aw_hold_q && w_hold_q;
  assign wr_sfr        = wr_fire && wstb_q && (aw_idx_q[9:8] == 2'h0);
  assign wr_loc        = sfr_resolve(aw_idx_q[7:0], indirect_pointer);
  assign ar_idx        = s_axi_araddr[11:2];

  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_idx_d  = aw_idx_q;
    w_hold_d  = w_hold_q;
    wd_d      = wd_q;
    wstb_d    = wstb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      aw_idx_d  = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wd_d     = s_axi_wdata[7:0];
      wstb_d   = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (aw_idx_q[9:8] == 2'h0 || aw_idx_q == IDX_IRQ_STATUS ||
                   aw_idx_q == IDX_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (!nrst) begin
      aw_hold_d = 1'b0;
      aw_idx_d  = 10'h000;
      w_hold_d  = 1'b0;
      wd_d      = 8'h00;
      wstb_d    = 1'b0;
      bvalid_d  = 1'b0;
      bresp_d   = RESP_OKAY;
    end
  end

  always_ff @(posedge clock) begin
    aw_hold_q <= aw_hold_d;
    aw_idx_q  <= aw_idx_d;
    w_hold_q  <= w_hold_d;
    wd_q      <= wd_d;
    wstb_q    <= wstb_d;
    bvalid_q  <= bvalid_d;
    bresp_q   <= bresp_d;
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rd_loc         = sfr_resolve(ar_idx[7:0], indirect_pointer);
    ram_bus.raddr  = GPR_AW'(rd_loc - GPR_BASE);
    rd_val         = 8'h00;
    rd_resp        = RESP_OKAY;
    if (ar_idx[9:8] != 2'h0) begin
      if (ar_idx == IDX_IRQ_STATUS)
        rd_val = 8'(ist_q);
      else if (ar_idx == IDX_IRQ_MASK)
        rd_val = 8'(imask_q);
      else
        rd_resp = RESP_SLVERR;
    end else if (rd_loc >= GPR_BASE && rd_loc < GPR_LIMIT) begin
      rd_val = ram_bus.rdata;
    end else if (rd_loc != IDX_INDIRECT_ACCESS_PORT &&
                 rd_loc <= IDX_LAST_SFR) begin
      if (rd_loc == IDX_PORT_A_LATCH)
        rd_val = {2'h0, port_a_pins};
      else if (rd_loc == IDX_PORT_B_LATCH)
        rd_val = port_b_pins;
      else if (rd_loc == IDX_PORT_C_LATCH)
        rd_val = port_c_pins;
      else
        rd_val = reg_q[rd_loc];
      rd_val = rd_val & sfr_impl_mask(rd_loc);
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rd_d     = rd_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rd_d     = rd_val;
      rresp_d  = rd_resp;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (!nrst) begin
      rvalid_d = 1'b0;
      rd_d     = 8'h00;
      rresp_d  = RESP_OKAY;
    end
  end

  always_ff @(posedge clock) begin
    rvalid_q <= rvalid_d;
    rd_q     <= rd_d;
    rresp_q  <= rresp_d;
  end

  // ****************************************************************
  // Register file, counter high bits, interrupt status
  // ****************************************************************
  always_comb begin
    ram_bus.we    = wr_sfr && wr_loc >= GPR_BASE && wr_loc < GPR_LIMIT;
    ram_bus.waddr = GPR_AW'(wr_loc - GPR_BASE);
    ram_bus.wdata = wd_q;
  end

  always_comb begin
    logic [7:0] wm;
    logic [7:0] rm;
    wm      = 8'h00;
    rm      = 8'h00;
    reg_d   = reg_q;
    pch_d   = pch_q;
    ist_d   = ist_q;
    imask_d = imask_q;
    if (wr_sfr) begin
      for (int i = 1; i <= int'(IDX_LAST_SFR); i++) begin
        if (wr_loc == 8'(i)) begin
          wm = sfr_impl_mask(8'(i));
          if (8'(i) == IDX_CPU_STATUS_WORD)
            wm = wm & ~STATUS_READ_ONLY;
          reg_d[i] = (reg_q[i] & ~wm) | (wd_q & wm);
        end
      end
      if (wr_loc == IDX_PROGRAM_COUNTER_LOW)
        pch_d = reg_q[IDX_PC_HIGH_BUFFER][PC_HIGH_W-1:0];
    end else if (wr_fire && wstb_q) begin
      if (aw_idx_q == IDX_IRQ_STATUS)
        ist_d = ist_q & ~wd_q[EVT_W-1:0];
      else if (aw_idx_q == IDX_IRQ_MASK)
        imask_d = wd_q[EVT_W-1:0];
    end
    // Hardware set wins over a clear in the same cycle
    reg_d[IDX_PERIPHERAL_IRQ_FLAGS][EVT_PIR_W-1:0] =
      reg_d[IDX_PERIPHERAL_IRQ_FLAGS][EVT_PIR_W-1:0] |
      event_in[EVT_PIR_W-1:0];
    reg_d[IDX_INTERRUPT_CONTROL][EVT_INTERRUPT_CONTROL_W-1:0] =
      reg_d[IDX_INTERRUPT_CONTROL][EVT_INTERRUPT_CONTROL_W-1:0] |
      event_in[EVT_W-1:EVT_PIR_W];
    ist_d = ist_d | event_in;
    if (!nrst) begin
      for (int i = 1; i <= int'(IDX_LAST_SFR); i++) begin
        rm       = sfr_rst_mask(8'(i), rst_power_cause);
        reg_d[i] = reg_q[i] & ~rm;
      end
      if (rst_power_cause)
        reg_d[IDX_CPU_STATUS_WORD] = reg_d[IDX_CPU_STATUS_WORD] |
                                     STATUS_POR_VALUE;
      else begin
        reg_d[IDX_CPU_STATUS_WORD][STATUS_TO_BIT] = rst_timeout_bit;
        reg_d[IDX_CPU_STATUS_WORD][STATUS_PD_BIT] = rst_powerdown_bit;
      end
      pch_d   = '0;
      ist_d   = '0;
      imask_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    reg_q   <= reg_d;
    pch_q   <= pch_d;
    ist_q   <= ist_d;
    imask_q <= imask_d;
  end

  assign port_a_out = reg_q[IDX_PORT_A_LATCH][5:0];
  assign port_b_out = reg_q[IDX_PORT_B_LATCH];
  assign port_c_out = reg_q[IDX_PORT_C_LATCH];
  assign pc_out     = {pch_q, reg_q[IDX_PROGRAM_COUNTER_LOW]};
  assign irq        = |(ist_q & imask_q);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking

  property p_unmapped_zero;
    disable iff (!nrst)
    (s_axi_arvalid && s_axi_arready && ar_idx[9:8] == 2'h0 &&
     sfr_impl_mask(rd_loc) == 8'h00 &&
     !(rd_loc >= GPR_BASE && rd_loc < GPR_LIMIT))
    |=> (s_axi_rvalid && s_axi_rdata == 32'h00000000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero");

  property p_mirror_status;
    disable iff (!nrst)
    (wr_sfr && aw_idx_q[7:0] == (IDX_CPU_STATUS_WORD | 8'h80))
    |=> (reg_q[IDX_CPU_STATUS_WORD][2:0] == $past(wd_q[2:0]));
  endproperty
  a_mirror_status: assert property (p_mirror_status)
    else $error("mirrored status write missed");

  property p_pch_guarded;
    disable iff (!nrst)
    !(wr_sfr && wr_loc == IDX_PROGRAM_COUNTER_LOW) |=> $stable(pch_q);
  endproperty
  a_pch_guarded: assert property (p_pch_guarded)
    else $error("upper counter bits changed without low byte write");

  property p_buffer_holds;
    disable iff (!nrst)
    (wr_sfr && wr_loc == IDX_PC_HIGH_BUFFER)
    |=> (reg_q[IDX_PC_HIGH_BUFFER][4:0] == $past(wd_q[4:0])) &&
        $stable(pch_q);
  endproperty
  a_buffer_holds: assert property (p_buffer_holds)
    else $error("high buffer write not held");

  property p_other_reset;
    (!nrst && !rst_power_cause)
    |=> (reg_q[IDX_TIMER_ONE_CONTROL] ==
         $past(reg_q[IDX_TIMER_ONE_CONTROL])) &&
        (reg_q[IDX_CPU_STATUS_WORD][STATUS_TO_BIT] ==
         $past(rst_timeout_bit)) &&
        (reg_q[IDX_CPU_STATUS_WORD][2:0] ==
         $past(reg_q[IDX_CPU_STATUS_WORD][2:0]));
  endproperty
  a_other_reset: assert property (p_other_reset)
    else $error("non-power-up reset values wrong");

  property p_por_status;
    (!nrst && rst_power_cause)
    |=> (reg_q[IDX_CPU_STATUS_WORD][7:3] == 5'h03) &&
        (reg_q[IDX_TIMER_ONE_CONTROL][5:0] == 6'h00);
  endproperty
  a_por_status: assert property (p_por_status)
    else $error("power-up reset values wrong");

  property p_pcl_copy;
    disable iff (!nrst)
    (wr_sfr && wr_loc == IDX_PROGRAM_COUNTER_LOW)
    |=> (pc_out == {$past(reg_q[IDX_PC_HIGH_BUFFER][4:0]), $past(wd_q)});
  endproperty
  a_pcl_copy: assert property (p_pcl_copy)
    else $error("counter not loaded from high buffer");

  property p_indirect_write;
    disable iff (!nrst)
    (wr_sfr && sfr_fold(aw_idx_q[7:0]) == IDX_INDIRECT_ACCESS_PORT &&
     indirect_pointer == IDX_PORT_B_LATCH)
    |=> (port_b_out == $past(wd_q));
  endproperty
  a_indirect_write: assert property (p_indirect_write)
    else $error("indirect write missed pointer target");

endmodule : sfr_top

// *** tb/sfr_core_model.sv ***
// Core model issuing register accesses over AXI4-Lite
`timescale 1ns/10ps
module sfr_core_model (
  input  wire logic        clock,   // Core clock
  output logic [11:0]      awaddr,  // Write addr
  output logic             awvalid, // Write addr valid
  input  wire logic        awready, // Write addr ready
  output logic [31:0]      wdata,   // Write data
  output logic [3:0]       wstrb,   // Byte enables
  output logic             wvalid,  // Write data valid
  input  wire logic        wready,  // Write data ready
  input  wire logic [1:0]  bresp,   // Write resp
  input  wire logic        bvalid,  // Write resp valid
  output logic             bready,  // Write resp ready
  output logic [11:0]      araddr,  // Read addr
  output logic             arvalid, // Read addr valid
  input  wire logic        arready, // Read addr ready
  input  wire logic [31:0] rdata,   // Read data
  input  wire logic [1:0]  rresp,   // Read resp
  input  wire logic        rvalid,  // Read data valid
  output logic             rready   // Read data ready
);
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic [7:0] v;
    logic       a_ok;
    logic       w_ok;
    v = d;
    if (a[11:2] inside {10'h003, 10'h083}) v[7:6] = 2'b00;
    if (a[11:2] inside {10'h00C, 10'h08C}) v[7:6] = 2'b00;
    if (a[11:2] == 10'h08E) v[0] = 1'b1;
    a_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clock);
      if (awready && !a_ok) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : sfr_core_model

// *** tb/sfr_top_bench.sv ***
// Register map bench driving accesses through the core model
`timescale 1ns/10ps
module sfr_top_bench;
  import sfr_pkg::*;
  logic clock, nrst, pcause, to_b, pd_b, awv, awr, wv, wr_r, bv, br;
  logic arv, arr, rv, rr, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  logic [6:0]  ev;
  logic [7:0]  pb, pbo, pco;
  logic [5:0]  pao;
  logic [12:0] pc;
  int          num_errors, checks, cycles, i;
  logic [11:0] zero_at [7] = '{12'h008, 12'h028, 12'h044, 12'h048,
                               12'h050, 12'h05C, 12'h030};

  sfr_top i_dut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .rst_power_cause(pcause), .rst_timeout_bit(to_b),
    .rst_powerdown_bit(pd_b), .event_in(ev), .port_a_pins(6'h15),
    .port_b_pins(pb), .port_c_pins(8'hC3), .port_a_out(pao),
    .port_b_out(pbo), .port_c_out(pco), .pc_out(pc), .irq(irq));
  sfr_core_model i_core (.clock(clock), .awaddr(awa), .awvalid(awv),
    .awready(awr), .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wr_r),
    .bresp(bresp), .bvalid(bv), .bready(br), .araddr(ara),
    .arvalid(arv), .arready(arr), .rdata(rdat), .rresp(rresp),
    .rvalid(rv), .rready(rr));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic w(input logic [11:0] a, input logic [7:0] d,
                   input logic [1:0] e = RESP_OKAY);
    logic [1:0] r;
    i_core.wr(a, d, r);
    chk($sformatf("bresp %h", a), {30'h0, e}, {30'h0, r});
  endtask : w

  task automatic rc(input logic [11:0] a, input logic [31:0] e,
                    input logic [7:0] m = 8'hFF,
                    input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    i_core.rd(a, d, r);
    chk($sformatf("rdata %h", a), e, d & {24'h0, m});
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, r});
  endtask : rc

  task automatic do_reset(input logic por);
    nrst <= 1'b0;
    pcause <= por;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
  endtask : do_reset

  initial begin
    {nrst, pcause, to_b, pd_b, num_errors, checks, cycles} = '0;
    ev = 7'h00;
    pb = 8'h5A;
    do_reset(1'b1);
    for (i = 0; i < 7; i++) rc(zero_at[i], 32'h0);
    rc(12'h00C, 32'h18, 8'hF8);
    w(12'h020, 8'hFF);
    rc(12'h020, 32'h0);
    rc(12'h060, 32'h0);
    w(12'h030, 8'h3F);
    rc(12'h030, 32'h0F);
    rc(12'h800, 32'h0, 8'hFF, RESP_SLVERR);
    rc(12'h018, 32'h5A);
    w(12'h018, 8'hC3);
    chk("port_b_out", 32'hC3, {24'h0, pbo});
    w(12'h014, 8'hFF);
    chk("port_a_out", 32'h3F, {26'h0, pao});
    rc(12'h014, 32'h15);
    w(12'h01C, 8'h96);
    chk("port_c_out", 32'h96, {24'h0, pco});
    rc(12'h01C, 32'hC3);
    w(12'h228, 8'h15);
    chk("pc high hold", 32'h0, {19'h0, pc});
    rc(12'h028, 32'h15);
    w(12'h008, 8'h34);
    chk("pc load", 32'h1534, {19'h0, pc});
    rc(12'h208, 32'h34);
    w(12'h010, 8'h25);
    w(12'h000, 8'hA5);
    rc(12'h094, 32'hA5);
    rc(12'h210, 32'h25);
    w(12'h210, 8'h0A);
    rc(12'h200, 32'h15);
    w(12'h010, 8'h06);
    w(12'h000, 8'h3C);
    chk("port_b_out indirect", 32'h3C, {24'h0, pbo});
    w(12'h010, 8'h00);
    rc(12'h000, 32'h0);
    w(12'h040, 8'h2A);
    w(12'h20C, 8'h07);
    rc(12'h00C, 32'h1F);
    w(12'h02C, 8'h81);
    pd_b <= 1'b1;
    do_reset(1'b0);
    rc(12'h040, 32'h2A);
    rc(12'h00C, 32'h0F);
    rc(12'h02C, 32'h01);
    do_reset(1'b1);
    rc(12'h040, 32'h0);
    ev <= 7'h01;
    @(posedge clock);
    ev <= 7'h00;
    rc(12'h400, 32'h01);
    rc(12'h030, 32'h01);
    chk("irq masked", 32'h0, {31'h0, irq});
    w(12'h404, 8'h01);
    chk("irq raised", 32'h1, {31'h0, irq});
    w(12'h400, 8'h01);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rc(12'h400, 32'h0);
    complete_run();
  end
endmodule : sfr_top_bench
